// *** ptp_default_dataset_regs.sv ***
`timescale 1ns/1ps

// Functional notes
// RULE_01 - software sets the snapshot flag; the device clears it, copies the live dataset into the readable fields and then sets the read-only done flag.
// RULE_02 - software sets a field's valid flag after writing it; the device takes the value into use and clears the flag itself.
// RULE_03 - valid flags sit at bit 0 identity, 1 domain, 2 quality, 3 first rank, 4 second rank, 5 short identity, 6 time error; bits 29:7 read zero.
// RULE_04 - the eight identity bytes sit in two words, bytes 0-3 then 4-7, byte 0 of each word in bits 7:0.
// RULE_05 - identity bytes 0 to 2 form the first three MAC bytes, least significant byte sent first.
// RULE_06 - identity bytes 5 to 7 form the last three MAC bytes, least significant byte first.
// RULE_07 - software deriving the identity from a MAC should write byte 3 as ff and byte 4 as fe.
// RULE_08 - one domain is supported; domain in bits 7:0, second rank in 23:16, first rank in 31:24.
// RULE_09 - class, accuracy and variance load with the profile defaults and may be overwritten later.
// RULE_10 - the short master identity acts only under the power profile and its bits 31:16 read zero.
// RULE_11 - the master time error acts only under the power profile.
// RULE_12 - the port count reads one always, resets to one, and bits 31:16 read zero.
// RULE_13 - a two-bit profile code selects default, power, utility or tsn and a change reloads clock defaults.
// RULE_14 - software changes configuration only while the core is disabled.
// RULE_15 - writes to reserved or read-only bits are ignored and reserved bits read zero.
module ptp_default_dataset_regs #(
    parameter int          ADDR_W          = 16,
    parameter logic [31:0] QUALITY_DEFAULT = 32'h1111_1111,
    parameter logic [31:0] QUALITY_POWER   = 32'h2222_2222,
    parameter logic [31:0] QUALITY_UTILITY = 32'h3333_3333,
    parameter logic [31:0] QUALITY_TSN     = 32'h4444_4444
) (
    // clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    input  wire logic [31:0]       reg_wdata_i,
    output logic      [31:0]       reg_rdata_o,
    output logic                   reg_ack_o,
    // profile code from the configuration block
    input  wire logic [1:0]        profile_i,
    // live dataset from the protocol engine
    input  wire logic [63:0]       live_identity_i,
    input  wire logic [7:0]        live_domain_i,
    input  wire logic [7:0]        live_first_rank_i,
    input  wire logic [7:0]        live_second_rank_i,
    input  wire logic [31:0]       live_quality_i,
    input  wire logic [15:0]       live_short_id_i,
    input  wire logic [31:0]       live_time_error_i,
    // dataset in use by the protocol engine
    output logic      [63:0]       node_identity_o,
    output logic      [47:0]       mac_address_o,
    output logic      [7:0]        sync_domain_number_o,
    output logic      [7:0]        first_selection_rank_o,
    output logic      [7:0]        second_selection_rank_o,
    output logic      [31:0]       quality_o,
    output logic      [15:0]       master_short_identity_o,
    output logic      [31:0]       master_time_error_o
);

    if (ADDR_W < 13 || ADDR_W > 16) begin : g_chk
        $error("ADDR_W must lie between 13 and 16");
    end

    typedef struct packed {
        ptp_dds_pkg::snap_e                 snap;
        logic                               done;
        logic                               read_req;
        logic [ptp_dds_pkg::VALID_W-1:0]    valid;
        logic [63:0]                        id_sh;
        logic [7:0]                         dom_sh;
        logic [7:0]                         first_sh;
        logic [7:0]                         second_sh;
        logic [31:0]                        q_sh;
        logic [15:0]                        gid_sh;
        logic [31:0]                        gte_sh;
        logic [15:0]                        gid_act;
        logic [31:0]                        gte_act;
        logic [63:0]                        id_o;
        logic [47:0]                        mac_o;
        logic [7:0]                         dom_o;
        logic [7:0]                         first_o;
        logic [7:0]                         second_o;
        logic [31:0]                        q_o;
        logic [15:0]                        gid_o;
        logic [31:0]                        gte_o;
        logic [31:0]                        rdata;
        logic                               ack;
    } regs_s;

    regs_s       r, n;
    logic [1:0]  prof;
    logic        prof_load;
    logic [31:0] prof_quality;
    logic [15:0] a;

    ptp_profile_quality #(
        .QUALITY_DEFAULT (QUALITY_DEFAULT),
        .QUALITY_POWER   (QUALITY_POWER),
        .QUALITY_UTILITY (QUALITY_UTILITY),
        .QUALITY_TSN     (QUALITY_TSN)
    ) u_profile (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .profile_i (profile_i),
        .profile_o (prof),
        .load_o    (prof_load),
        .quality_o (prof_quality)
    );

    // narrow or full address is compared as a 16-bit byte address
    assign a = 16'(reg_addr_i);

    always_comb begin
        n     = r;
        n.ack = reg_rd_i;
        // taking fields into use: hardware clears each flag it served
        if (r.valid[ptp_dds_pkg::BIT_IDENTITY_VALID]) begin
            n.id_o  = r.id_sh; // RULE_02
            n.mac_o = {r.id_sh[7:0], r.id_sh[15:8], r.id_sh[23:16],
                       r.id_sh[47:40], r.id_sh[55:48],
                       r.id_sh[63:56]}; // RULE_05 RULE_06
        end
        if (r.valid[ptp_dds_pkg::BIT_DOMAIN_VALID]) begin
            n.dom_o = r.dom_sh;
        end
        if (r.valid[ptp_dds_pkg::BIT_QUALITY_VALID]) begin
            n.q_o = r.q_sh;
        end
        if (r.valid[ptp_dds_pkg::BIT_FIRST_VALID]) begin
            n.first_o = r.first_sh;
        end
        if (r.valid[ptp_dds_pkg::BIT_SECOND_VALID]) begin
            n.second_o = r.second_sh;
        end
        if (r.valid[ptp_dds_pkg::BIT_SHORT_ID_VALID]) begin
            n.gid_act = r.gid_sh;
        end
        if (r.valid[ptp_dds_pkg::BIT_TIME_ERR_VALID]) begin
            n.gte_act = r.gte_sh;
        end
        n.valid = '0; // RULE_02
        // profile change reloads the quality word in both copies
        if (prof_load) begin
            n.q_sh = prof_quality; // RULE_09 RULE_13
            n.q_o  = prof_quality;
        end
        // snapshot sequencer: clear the request, then copy and flag done
        case (r.snap)
            ptp_dds_pkg::SNAP_IDLE: begin
                if (r.read_req) begin
                    n.read_req = 1'b0; // RULE_01
                    n.snap     = ptp_dds_pkg::SNAP_COPY;
                end
            end
            ptp_dds_pkg::SNAP_COPY: begin
                n.id_sh     = live_identity_i; // RULE_01
                n.dom_sh    = live_domain_i;
                n.first_sh  = live_first_rank_i;
                n.second_sh = live_second_rank_i;
                n.q_sh      = live_quality_i;
                n.gid_sh    = live_short_id_i;
                n.gte_sh    = live_time_error_i;
                n.done      = 1'b1;
                n.snap      = ptp_dds_pkg::SNAP_IDLE;
            end
            default: begin
                n.snap = ptp_dds_pkg::SNAP_IDLE;
            end
        endcase
        // software writes come last so a written field overrides any hardware update of it in the same cycle
        if (reg_wr_i) begin
            if (a == ptp_dds_pkg::OFS_CONTROL) begin
                n.valid = reg_wdata_i[ptp_dds_pkg::VALID_W-1:0]; // RULE_03
                if (reg_wdata_i[ptp_dds_pkg::BIT_READ]) begin
                    n.read_req = 1'b1; // RULE_01
                    n.done     = 1'b0;
                end
            end else if (a == ptp_dds_pkg::OFS_ID_LOW) begin
                n.id_sh[31:0] = reg_wdata_i; // RULE_04
            end else if (a == ptp_dds_pkg::OFS_ID_HIGH) begin
                n.id_sh[63:32] = reg_wdata_i; // RULE_04
            end else if (a == ptp_dds_pkg::OFS_DOMAIN_RANK) begin
                n.dom_sh    = reg_wdata_i[ptp_dds_pkg::POS_DOMAIN +: 8];
                n.second_sh = reg_wdata_i[ptp_dds_pkg::POS_SECOND +: 8];
                n.first_sh  = reg_wdata_i[ptp_dds_pkg::POS_FIRST +: 8];
            end else if (a == ptp_dds_pkg::OFS_QUALITY) begin
                n.q_sh = reg_wdata_i; // RULE_09
            end else if (a == ptp_dds_pkg::OFS_SHORT_ID) begin
                n.gid_sh = reg_wdata_i[15:0]; // RULE_15
            end else if (a == ptp_dds_pkg::OFS_TIME_ERROR) begin
                n.gte_sh = reg_wdata_i;
            end
        end
        // power-only fields are withheld under every other profile
        n.gid_o = (prof == ptp_dds_pkg::PROF_POWER) ? n.gid_act : '0; // RULE_10
        n.gte_o = (prof == ptp_dds_pkg::PROF_POWER) ? n.gte_act : '0; // RULE_11
        // read data reflects state before this cycle's write
        n.rdata = ptp_dds_pkg::RST_ZERO;
        if (reg_rd_i) begin
            if (a == ptp_dds_pkg::OFS_CONTROL) begin
                n.rdata[ptp_dds_pkg::BIT_READ_DONE] = r.done;
                n.rdata[ptp_dds_pkg::BIT_READ]      = r.read_req;
                n.rdata[ptp_dds_pkg::VALID_W-1:0]   = r.valid; // RULE_15
            end else if (a == ptp_dds_pkg::OFS_ID_LOW) begin
                n.rdata = r.id_sh[31:0];
            end else if (a == ptp_dds_pkg::OFS_ID_HIGH) begin
                n.rdata = r.id_sh[63:32];
            end else if (a == ptp_dds_pkg::OFS_DOMAIN_RANK) begin
                n.rdata[ptp_dds_pkg::POS_DOMAIN +: 8] = r.dom_sh; // RULE_08
                n.rdata[ptp_dds_pkg::POS_SECOND +: 8] = r.second_sh;
                n.rdata[ptp_dds_pkg::POS_FIRST +: 8]  = r.first_sh;
            end else if (a == ptp_dds_pkg::OFS_QUALITY) begin
                n.rdata = r.q_sh;
            end else if (a == ptp_dds_pkg::OFS_SHORT_ID) begin
                n.rdata[15:0] = r.gid_sh; // RULE_10
            end else if (a == ptp_dds_pkg::OFS_TIME_ERROR) begin
                n.rdata = r.gte_sh; // RULE_11
            end else if (a == ptp_dds_pkg::OFS_PORT_COUNT) begin
                n.rdata[15:0] = ptp_dds_pkg::RST_PORT_COUNT; // RULE_12
            end
        end
    end

    // single state register; port count lives only as a constant
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            r      <= '0;
            r.snap <= ptp_dds_pkg::SNAP_IDLE;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata_o             = r.rdata;
    assign reg_ack_o               = r.ack;
    assign node_identity_o         = r.id_o;
    assign mac_address_o           = r.mac_o;
    assign sync_domain_number_o    = r.dom_o;
    assign first_selection_rank_o  = r.first_o;
    assign second_selection_rank_o = r.second_o;
    assign quality_o               = r.q_o;
    assign master_short_identity_o = r.gid_o;
    assign master_time_error_o     = r.gte_o;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    logic wr_ctl;
    assign wr_ctl = reg_wr_i && (a == ptp_dds_pkg::OFS_CONTROL);

    AST_SNAP_DONE: assert property ( // RULE_01
        wr_ctl && reg_wdata_i[ptp_dds_pkg::BIT_READ] ##1 !wr_ctl [*2]
        |-> ##1 r.done)
        else $error("snapshot did not complete in three cycles");
    AST_READ_CLEARS: assert property ( // RULE_01
        r.read_req && !wr_ctl |=> !r.read_req)
        else $error("snapshot request flag not cleared");
    AST_VALID_CLEARS: assert property ( // RULE_02
        (r.valid != '0) && !wr_ctl |=> r.valid == '0)
        else $error("valid flag not cleared after use");
    AST_ID_TAKEN: assert property ( // RULE_03
        r.valid[ptp_dds_pkg::BIT_IDENTITY_VALID] |=>
        r.id_o == $past(r.id_sh))
        else $error("identity not taken into use");
    AST_ID_LAYOUT: assert property ( // RULE_04
        reg_rd_i && a == ptp_dds_pkg::OFS_ID_HIGH |=>
        reg_ack_o && reg_rdata_o == $past(r.id_sh[63:32]))
        else $error("identity high word misplaced");
    AST_MAC_MAP: assert property ( // RULE_06
        mac_address_o == {node_identity_o[7:0], node_identity_o[15:8],
        node_identity_o[23:16], node_identity_o[47:40],
        node_identity_o[55:48], node_identity_o[63:56]})
        else $error("mac bytes do not follow identity");
    AST_RANK_LAYOUT: assert property ( // RULE_08
        reg_rd_i && a == ptp_dds_pkg::OFS_DOMAIN_RANK |=>
        reg_rdata_o[15:8] == 8'h00
        && reg_rdata_o[31:24] == $past(r.first_sh))
        else $error("domain and rank layout wrong");
    AST_SHORT_ID_GATE: assert property ( // RULE_10
        prof != ptp_dds_pkg::PROF_POWER |=> master_short_identity_o == '0)
        else $error("short identity leaks outside power profile");
    AST_TIME_ERR_GATE: assert property ( // RULE_11
        prof != ptp_dds_pkg::PROF_POWER |=> master_time_error_o == '0)
        else $error("time error leaks outside power profile");
    AST_PORT_COUNT: assert property ( // RULE_12
        reg_rd_i && a == ptp_dds_pkg::OFS_PORT_COUNT |=>
        reg_rdata_o == 32'h0000_0001)
        else $error("port count is not one");
    AST_PROFILE_LOAD: assert property ( // RULE_13
        prof_load && !(r.snap == ptp_dds_pkg::SNAP_COPY) |=>
        quality_o == $past(prof_quality))
        else $error("profile defaults not loaded");
    AST_RESERVED_ZERO: assert property ( // RULE_15
        reg_rd_i && a == ptp_dds_pkg::OFS_CONTROL |=>
        reg_rdata_o[29:7] == '0)
        else $error("reserved control bits not zero");

    COV_SNAPSHOT: cover property (r.snap == ptp_dds_pkg::SNAP_COPY);
    COV_POWER_ID: cover property (master_short_identity_o != '0);
    COV_ALL_VALID: cover property (r.valid == 7'h7f);
    COV_SET_BEATS_CLEAR: cover property (r.valid != '0 && wr_ctl);

endmodule // ptp_default_dataset_regs

// *** ptp_dds_pkg.sv ***
package ptp_dds_pkg;

    // register byte offsets
    localparam logic [15:0] OFS_CONTROL      = 16'h1100;
    localparam logic [15:0] OFS_ID_LOW       = 16'h1104;
    localparam logic [15:0] OFS_ID_HIGH      = 16'h1108;
    localparam logic [15:0] OFS_DOMAIN_RANK  = 16'h110c;
    localparam logic [15:0] OFS_QUALITY      = 16'h1110;
    localparam logic [15:0] OFS_SHORT_ID     = 16'h1114;
    localparam logic [15:0] OFS_TIME_ERROR   = 16'h1118;
    localparam logic [15:0] OFS_PORT_COUNT   = 16'h111c;

    // control register field positions
    localparam int BIT_READ_DONE       = 31;
    localparam int BIT_READ            = 30;
    localparam int VALID_W             = 7;
    localparam int BIT_IDENTITY_VALID  = 0;
    localparam int BIT_DOMAIN_VALID    = 1;
    localparam int BIT_QUALITY_VALID   = 2;
    localparam int BIT_FIRST_VALID     = 3;
    localparam int BIT_SECOND_VALID    = 4;
    localparam int BIT_SHORT_ID_VALID  = 5;
    localparam int BIT_TIME_ERR_VALID  = 6;

    // domain and priority field positions
    localparam int POS_DOMAIN = 0;
    localparam int POS_SECOND = 16;
    localparam int POS_FIRST  = 24;

    // reset values
    localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
    localparam logic [15:0] RST_PORT_COUNT = 16'h0001;

    // running profile codes
    localparam logic [1:0] PROF_DEFAULT = 2'h0;
    localparam logic [1:0] PROF_POWER   = 2'h1;
    localparam logic [1:0] PROF_UTILITY = 2'h2;
    localparam logic [1:0] PROF_TSN     = 2'h3;

    // snapshot sequencer states, one-hot
    typedef enum logic [1:0] {
        SNAP_IDLE = 2'b01,
        SNAP_COPY = 2'b10
    } snap_e;

endpackage

// *** ptp_profile_quality.sv ***
`timescale 1ns/1ps

// holds the running profile and pulses a reload of its clock quality
module ptp_profile_quality #(
    parameter logic [31:0] QUALITY_DEFAULT = 32'h1111_1111,
    parameter logic [31:0] QUALITY_POWER   = 32'h2222_2222,
    parameter logic [31:0] QUALITY_UTILITY = 32'h3333_3333,
    parameter logic [31:0] QUALITY_TSN     = 32'h4444_4444
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // profile selection
    input  wire logic [1:0]  profile_i,
    // registered profile, reload pulse and quality word
    output logic      [1:0]  profile_o,
    output logic             load_o,
    output logic      [31:0] quality_o
);

    typedef struct packed {
        logic        started;
        logic [1:0]  prof;
        logic        load;
        logic [31:0] quality;
    } pq_s;

    pq_s r, n;

    function automatic logic [31:0] lut(input logic [1:0] p);
        case (p)
            ptp_dds_pkg::PROF_POWER:   lut = QUALITY_POWER;
            ptp_dds_pkg::PROF_UTILITY: lut = QUALITY_UTILITY;
            ptp_dds_pkg::PROF_TSN:     lut = QUALITY_TSN;
            default:                   lut = QUALITY_DEFAULT;
        endcase
    endfunction

    // reload once after reset and on every change of the code
    always_comb begin
        n         = r;
        n.started = 1'b1;
        n.prof    = profile_i;
        n.load    = !r.started || (profile_i != r.prof); // RULE_13
        n.quality = lut(profile_i); // RULE_09
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign profile_o = r.prof;
    assign load_o    = r.load;
    assign quality_o = r.quality;

endmodule // ptp_profile_quality

// *** tb.sv ***
`timescale 1ns/1ps

module tb;
    // quality defaults chosen here so each profile code is distinguishable
    localparam logic [31:0] Q_DEF = 32'ha1b2c3d4;
    localparam logic [31:0] Q_PWR = 32'hb2c3d4e5;
    localparam logic [31:0] Q_UTL = 32'hc3d4e5f6;
    localparam logic [31:0] Q_TSN = 32'hd4e5f607;

    logic        mclk_i;
    logic        rst_i;
    logic [15:0] reg_addr_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [31:0] reg_wdata_i;
    logic [31:0] reg_rdata_o;
    logic        reg_ack_o;
    logic [1:0]  profile_i;
    logic [63:0] live_identity_i;
    logic [7:0]  live_domain_i;
    logic [7:0]  live_first_rank_i;
    logic [7:0]  live_second_rank_i;
    logic [31:0] live_quality_i;
    logic [15:0] live_short_id_i;
    logic [31:0] live_time_error_i;
    logic [63:0] node_identity_o;
    logic [47:0] mac_address_o;
    logic [7:0]  sync_domain_number_o;
    logic [7:0]  first_selection_rank_o;
    logic [7:0]  second_selection_rank_o;
    logic [31:0] quality_o;
    logic [15:0] master_short_identity_o;
    logic [31:0] master_time_error_o;

    logic [31:0] exp_q[$];
    logic [31:0] qtab[4];
    int          n_fail;
    int          check_count;

    ptp_default_dataset_regs #(
        .ADDR_W(16), .QUALITY_DEFAULT(Q_DEF), .QUALITY_POWER(Q_PWR),
        .QUALITY_UTILITY(Q_UTL), .QUALITY_TSN(Q_TSN)
    ) dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
        .profile_i(profile_i), .live_identity_i(live_identity_i),
        .live_domain_i(live_domain_i), .live_first_rank_i(live_first_rank_i),
        .live_second_rank_i(live_second_rank_i),
        .live_quality_i(live_quality_i), .live_short_id_i(live_short_id_i),
        .live_time_error_i(live_time_error_i),
        .node_identity_o(node_identity_o), .mac_address_o(mac_address_o),
        .sync_domain_number_o(sync_domain_number_o),
        .first_selection_rank_o(first_selection_rank_o),
        .second_selection_rank_o(second_selection_rank_o),
        .quality_o(quality_o),
        .master_short_identity_o(master_short_identity_o),
        .master_time_error_o(master_time_error_o)
    );

    // free-running 50 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    task automatic fail(input string what);
        n_fail++;
        $display("[ERR] %0t %s", $time, what);
    endtask

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) fail($sformatf("read %h exp %h", got, exp));
    endtask

    task automatic chk_out(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) fail($sformatf("output %h exp %h", got, exp));
    endtask

    // ack is registered, so it is sampled one edge after it lands
    always @(posedge mclk_i) begin
        if (reg_ack_o === 1'b1) begin
            if (exp_q.size() == 0) fail("answer without a pending read");
            else chk_rd(reg_rdata_o, exp_q.pop_front());
        end
    end

    task automatic idle(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // one-cycle strobes; the trailing edge keeps back-to-back calls legal
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        exp_q.push_back(e);
        @(posedge mclk_i);
        reg_rd_i   <= 1'b0;
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic rd_reset_vals();
        rd(ptp_dds_pkg::OFS_CONTROL, 32'h0000_0000);
        rd(ptp_dds_pkg::OFS_ID_LOW, 32'h0000_0000);
        rd(ptp_dds_pkg::OFS_ID_HIGH, 32'h0000_0000);
        rd(ptp_dds_pkg::OFS_DOMAIN_RANK, 32'h0000_0000);
        rd(ptp_dds_pkg::OFS_QUALITY, Q_DEF);
        rd(ptp_dds_pkg::OFS_SHORT_ID, 32'h0000_0000);
        rd(ptp_dds_pkg::OFS_TIME_ERROR, 32'h0000_0000);
        rd(ptp_dds_pkg::OFS_PORT_COUNT, 32'h0000_0001);
    endtask

    initial begin : main
        logic [31:0] lo, hi, dr, qv, sid, ter;
        logic [1:0]  p;
        qtab = '{Q_DEF, Q_PWR, Q_UTL, Q_TSN};
        n_fail = 0;
        check_count = 0;
        rst_i = 1'b1;
        reg_addr_i = 16'h0000;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_wdata_i = 32'h0000_0000;
        profile_i = ptp_dds_pkg::PROF_DEFAULT;
        live_identity_i = 64'h0;
        live_domain_i = 8'h0;
        live_first_rank_i = 8'h0;
        live_second_rank_i = 8'h0;
        live_quality_i = 32'h0;
        live_short_id_i = 16'h0;
        live_time_error_i = 32'h0;
        void'($urandom(8));
        idle(20);
        rst_i <= 1'b0;
        idle(3);
        rd_reset_vals();
        $display("test reset values done");

        // every profile code reloads its quality; the core stays disabled
        for (int k = 1; k <= 4; k++) begin
            p = k[1:0];
            @(posedge mclk_i);
            profile_i <= p;
            idle(4);
            chk_out({32'h0, quality_o}, {32'h0, qtab[p]});
            rd(ptp_dds_pkg::OFS_QUALITY, qtab[p]);
        end
        $display("test profile reload done");

        // power profile so the master fields take effect
        @(posedge mclk_i);
        profile_i <= ptp_dds_pkg::PROF_POWER;
        idle(4);
        lo = {8'hff, 24'($urandom)};
        hi = {24'($urandom), 8'hfe};
        dr = $urandom;
        qv = $urandom;
        sid = $urandom;
        ter = $urandom;
        wr(ptp_dds_pkg::OFS_ID_LOW, lo);
        wr(ptp_dds_pkg::OFS_ID_HIGH, hi);
        wr(ptp_dds_pkg::OFS_DOMAIN_RANK, dr);
        wr(ptp_dds_pkg::OFS_QUALITY, qv);
        wr(ptp_dds_pkg::OFS_SHORT_ID, sid);
        wr(ptp_dds_pkg::OFS_TIME_ERROR, ter);
        wr(ptp_dds_pkg::OFS_PORT_COUNT, 32'hffff_ffff);
        wr(ptp_dds_pkg::OFS_CONTROL, 32'hbfff_ff80);
        idle(3);
        chk_out(node_identity_o, 64'h0);
        rd(ptp_dds_pkg::OFS_CONTROL, 32'h0000_0000);
        rd(ptp_dds_pkg::OFS_ID_LOW, lo);
        rd(ptp_dds_pkg::OFS_ID_HIGH, hi);
        rd(ptp_dds_pkg::OFS_DOMAIN_RANK, dr & 32'hffff_00ff);
        rd(ptp_dds_pkg::OFS_QUALITY, qv);
        rd(ptp_dds_pkg::OFS_SHORT_ID, sid & 32'h0000_ffff);
        rd(ptp_dds_pkg::OFS_TIME_ERROR, ter);
        rd(ptp_dds_pkg::OFS_PORT_COUNT, 32'h0000_0001);
        rd(16'h1120, 32'h0000_0000);
        wr(ptp_dds_pkg::OFS_CONTROL, 32'h0000_007f);
        idle(3);
        rd(ptp_dds_pkg::OFS_CONTROL, 32'h0000_0000);
        chk_out(node_identity_o, {hi, lo});
        chk_out({16'h0, mac_address_o}, {16'h0, lo[7:0], lo[15:8],
            lo[23:16], hi[15:8], hi[23:16], hi[31:24]});
        chk_out({56'h0, sync_domain_number_o}, {56'h0, dr[7:0]});
        chk_out({56'h0, first_selection_rank_o}, {56'h0, dr[31:24]});
        chk_out({56'h0, second_selection_rank_o}, {56'h0, dr[23:16]});
        chk_out({32'h0, quality_o}, {32'h0, qv});
        chk_out({48'h0, master_short_identity_o}, {48'h0, sid[15:0]});
        chk_out({32'h0, master_time_error_o}, {32'h0, ter});
        // a field written without its flag is not taken into use
        wr(ptp_dds_pkg::OFS_ID_LOW, ~lo);
        idle(3);
        chk_out(node_identity_o, {hi, lo});
        // back-to-back flag writes: the new set beats the hardware clear
        wr(ptp_dds_pkg::OFS_DOMAIN_RANK, ~dr);
        @(posedge mclk_i);
        reg_addr_i  <= ptp_dds_pkg::OFS_CONTROL;
        reg_wdata_i <= 32'h0000_0008;
        reg_wr_i    <= 1'b1;
        @(posedge mclk_i);
        reg_wdata_i <= 32'h0000_0002;
        @(posedge mclk_i);
        reg_wr_i    <= 1'b0;
        idle(3);
        chk_out({56'h0, sync_domain_number_o}, {56'h0, ~dr[7:0]});
        chk_out({56'h0, first_selection_rank_o}, {56'h0, ~dr[31:24]});
        @(posedge mclk_i);
        profile_i <= ptp_dds_pkg::PROF_UTILITY;
        idle(4);
        chk_out({48'h0, master_short_identity_o}, 64'h0);
        chk_out({32'h0, master_time_error_o}, 64'h0);
        $display("test field valid done");

        // snapshot of the live dataset into the readable fields
        @(posedge mclk_i);
        live_identity_i <= {$urandom, $urandom};
        live_domain_i <= 8'($urandom);
        live_first_rank_i <= 8'($urandom);
        live_second_rank_i <= 8'($urandom);
        live_quality_i <= $urandom;
        live_short_id_i <= 16'($urandom);
        live_time_error_i <= $urandom;
        wr(ptp_dds_pkg::OFS_CONTROL, 32'h4000_0000);
        idle(5);
        rd(ptp_dds_pkg::OFS_CONTROL, 32'h8000_0000);
        rd(ptp_dds_pkg::OFS_ID_LOW, live_identity_i[31:0]);
        rd(ptp_dds_pkg::OFS_ID_HIGH, live_identity_i[63:32]);
        rd(ptp_dds_pkg::OFS_DOMAIN_RANK, {live_first_rank_i,
            live_second_rank_i, 8'h00, live_domain_i});
        rd(ptp_dds_pkg::OFS_QUALITY, live_quality_i);
        rd(ptp_dds_pkg::OFS_SHORT_ID, {16'h0, live_short_id_i});
        rd(ptp_dds_pkg::OFS_TIME_ERROR, live_time_error_i);
        $display("test snapshot done");

        // reset in mid-run must bring the table back
        @(posedge mclk_i);
        profile_i <= ptp_dds_pkg::PROF_DEFAULT;
        rst_i <= 1'b1;
        idle(3);
        rst_i <= 1'b0;
        idle(3);
        rd_reset_vals();
        $display("test second reset done");

        for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge mclk_i);
        if (exp_q.size() != 0) fail("read answers missing");
        report_and_stop();
    end
endmodule // tb
